// ### common/asb_params.svh
// Constants for the auxiliary sensor bus master and bypass
`ifndef ASB_PARAMS_SVH
`define ASB_PARAMS_SVH
`define ASB_NUM_BURST_CH     4
`define ASB_MAX_BURST_BYTES  24
`define ASB_SINGLE_CH        4
`define ASB_FIFO_BYTES       512
`define ASB_FIFO_CNT_W       10
`define ASB_SCL_FREQ_KHZ     400
`define ASB_CLK_FREQ_KHZ     100000
`define ASB_HALF_BIT_CYC     ((`ASB_CLK_FREQ_KHZ / `ASB_SCL_FREQ_KHZ) / 2)
`define ASB_MAG_ADDR         7'h0c
`define ASB_BIT_LAST         3'h7
`define ASB_DIV_W            8
`define ASB_BYTE_CNT_W       5
`endif

// ### common/asb_pkg.sv
// Types for the auxiliary sensor bus master and bypass
package asb_pkg;
	typedef struct packed {
		logic       en;
		logic       rd;
		logic [6:0] dev;
		logic [7:0] reg_addr;
		logic [4:0] len;
		logic       to_fifo;
	} asb_chan_cfg_s;

	typedef struct packed {
		logic       en;
		logic       rd;
		logic [6:0] dev;
		logic [7:0] reg_addr;
		logic [7:0] wdata;
	} asb_single_cfg_s;

	typedef struct packed {
		logic nack;
		logic lost_arb;
		logic data_ready;
		logic single_done;
	} asb_event_s;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_START  = 4'b0001,
		ST_ADDR   = 4'b0010,
		ST_AACK   = 4'b0011,
		ST_WBYTE  = 4'b0100,
		ST_WACK   = 4'b0101,
		ST_RSTART = 4'b0110,
		ST_RBYTE  = 4'b0111,
		ST_RACK   = 4'b1000,
		ST_STOP   = 4'b1001,
		ST_NEXT   = 4'b1010
	} asb_state_e;
endpackage

// ### rtl/asb_fifo.sv
// Byte FIFO with valid/ready on both sides and an occupancy count
`timescale 1ns/10ps
`include "asb_params.svh"
module asb_fifo
	import asb_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [WIDTH-1:0]         in_data,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	output logic [WIDTH-1:0]              out_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [$clog2(DEPTH+1)-1:0]    count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0]           mem [DEPTH];
	logic [AW-1:0]              wptr_r;
	logic [AW-1:0]              rptr_r;
	logic [$clog2(DEPTH+1)-1:0] cnt_r;
	logic                       push;
	logic                       pop;

	assign in_ready  = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rptr_r];
	assign count     = cnt_r;

	always_ff @(posedge clk) begin
		if (push)
			mem[wptr_r] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (push)
				wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
			if (pop)
				rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
		end
	end

	// Count tracks valid entries exactly
	always_ff @(posedge clk) begin
		if (rst)
			cnt_r <= '0;
		else if (push && !pop)
			cnt_r <= cnt_r + 1'b1;
		else if (pop && !push)
			cnt_r <= cnt_r - 1'b1;
	end
endmodule // asb_fifo

// ### rtl/asb_master.sv
// Auxiliary sensor bus master with host bypass, data registers and FIFO
`timescale 1ns/10ps
`include "asb_params.svh"
module asb_master
	import asb_pkg::*;
#(
	parameter int FIFO_DEPTH = 32,
	parameter int HALF_CYC   = `ASB_HALF_BIT_CYC
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          link_clk,
	input  wire logic                          master_en,
	input  wire logic                          bypass_en,
	input  wire logic                          spi_mode,
	input  wire logic                          start_cycle,
	input  wire asb_chan_cfg_s                 chan_cfg [`ASB_NUM_BURST_CH],
	input  wire asb_single_cfg_s               single_cfg,
	output logic [7:0]                         single_rdata,
	output logic [7:0]                         sensor_data [`ASB_MAX_BURST_BYTES],
	output asb_event_s                         events,
	output logic                               busy,
	output logic [7:0]                         fifo_data,
	output logic                               fifo_valid,
	input  wire logic                          fifo_ready,
	output logic [$clog2(FIFO_DEPTH+1)-1:0]    fifo_count,
	input  wire logic                          host_scl_in,
	input  wire logic                          host_sda_in,
	output logic                               host_sda_out,
	output logic                               host_sda_oe,
	output logic                               host_scl_out,
	output logic                               host_scl_oe,
	input  wire logic                          sensor_bus_clock_pin_in,
	output logic                               sensor_bus_clock_pin_out,
	output logic                               sensor_bus_clock_pin_oe,
	input  wire logic                          sensor_bus_data_pin_in,
	output logic                               sensor_bus_data_pin_out,
	output logic                               sensor_bus_data_pin_oe
);
	// ==============================================================
	// Bypass path
	// ==============================================================
	logic       bypass_on;
	logic [1:0] aux_scl_sync_r;
	logic [1:0] aux_sda_sync_r;
	logic [1:0] host_scl_sync_r;
	logic [1:0] host_sda_sync_r;
	logic       link_start_r;
	logic [1:0] start_sync_r;
	logic       start_tgl_r;
	logic       start_seen_r;
	logic [2:0] sda_fwd_r;
	logic [2:0] scl_fwd_r;
	logic [2:0] sda_back_r;
	logic [2:0] scl_back_r;

	assign bypass_on = bypass_en && !spi_mode;

	// Recent own drive per direction, blocks echo latch-up
	always_ff @(posedge clk) begin
		if (rst) begin
			sda_fwd_r  <= 3'h0;
			scl_fwd_r  <= 3'h0;
			sda_back_r <= 3'h0;
			scl_back_r <= 3'h0;
		end else begin
			sda_fwd_r  <= {sda_fwd_r[1:0], sensor_bus_data_pin_oe};
			scl_fwd_r  <= {scl_fwd_r[1:0], sensor_bus_clock_pin_oe};
			sda_back_r <= {sda_back_r[1:0], host_sda_oe};
			scl_back_r <= {scl_back_r[1:0], host_scl_oe};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			aux_scl_sync_r  <= 2'h3;
			aux_sda_sync_r  <= 2'h3;
			host_scl_sync_r <= 2'h3;
			host_sda_sync_r <= 2'h3;
		end else begin
			aux_scl_sync_r  <= {aux_scl_sync_r[0], sensor_bus_clock_pin_in};
			aux_sda_sync_r  <= {aux_sda_sync_r[0], sensor_bus_data_pin_in};
			host_scl_sync_r <= {host_scl_sync_r[0], host_scl_in};
			host_sda_sync_r <= {host_sda_sync_r[0], host_sda_in};
		end
	end

	// ==============================================================
	// Start request crossing from the link clock
	// ==============================================================
	always_ff @(posedge link_clk) begin
		if (rst)
			link_start_r <= 1'b0;
		else if (start_cycle)
			link_start_r <= ~link_start_r;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			start_sync_r <= 2'h0;
			start_tgl_r  <= 1'b0;
		end else begin
			start_sync_r <= {start_sync_r[0], link_start_r};
			start_tgl_r  <= start_sync_r[1];
		end
	end

	assign start_seen_r = start_sync_r[1] ^ start_tgl_r;

	// ==============================================================
	// Bit timing
	// ==============================================================
	asb_state_e                  state_r;
	logic [`ASB_DIV_W-1:0]       div_r;
	logic [1:0]                  phase_r;
	logic                        tick;
	logic [2:0]                  bit_r;
	logic [7:0]                  shift_r;
	logic [2:0]                  chan_r;
	logic [`ASB_BYTE_CNT_W-1:0]  left_r;
	logic [`ASB_BYTE_CNT_W-1:0]  slot_r;
	logic                        rd_phase_r;
	logic                        scl_drv_r;
	logic                        sda_drv_r;
	logic                        nack_r;
	logic                        arb_r;
	logic                        any_data_r;
	logic                        single_ev_r;
	logic                        push;
	logic                        push_ready;
	logic                        sda_now;

	function automatic logic chan_active(input logic [2:0] c, input asb_chan_cfg_s cfg [`ASB_NUM_BURST_CH],
			input asb_single_cfg_s s);
		if (c == 3'(`ASB_SINGLE_CH))
			return s.en;
		return cfg[c[1:0]].en && (cfg[c[1:0]].len != '0);
	endfunction

	assign tick    = (div_r == `ASB_DIV_W'(HALF_CYC - 1));
	assign sda_now = aux_sda_sync_r[1];

	always_ff @(posedge clk) begin
		if (rst || state_r == ST_IDLE) begin
			div_r   <= '0;
			phase_r <= 2'h0;
		end else if (!(phase_r == 2'h2 && !aux_scl_sync_r[1])) begin
			div_r <= tick ? '0 : div_r + 1'b1;
			if (tick)
				phase_r <= phase_r + 1'b1;
		end
	end

	// ==============================================================
	// Transaction sequencer
	// ==============================================================
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r     <= ST_IDLE;
			chan_r      <= '0;
			bit_r       <= '0;
			shift_r     <= '0;
			left_r      <= '0;
			slot_r      <= '0;
			rd_phase_r  <= 1'b0;
			scl_drv_r   <= 1'b0;
			sda_drv_r   <= 1'b0;
			nack_r      <= 1'b0;
			arb_r       <= 1'b0;
			any_data_r  <= 1'b0;
			single_ev_r <= 1'b0;
		end else begin
			nack_r      <= 1'b0;
			arb_r       <= 1'b0;
			any_data_r  <= 1'b0;
			single_ev_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					scl_drv_r <= 1'b0;
					sda_drv_r <= 1'b0;
					if (master_en && !bypass_on && start_seen_r) begin
						chan_r <= '0;
						slot_r <= '0;
						state_r <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					if (bypass_on || chan_r > 3'(`ASB_SINGLE_CH)) begin
						state_r <= ST_IDLE;
						any_data_r <= (slot_r != '0);
					end else if (chan_active(chan_r, chan_cfg, single_cfg)) begin
						rd_phase_r <= 1'b0;
						left_r <= (chan_r == 3'(`ASB_SINGLE_CH)) ? `ASB_BYTE_CNT_W'(1) : chan_cfg[chan_r[1:0]].len;
						state_r <= ST_START;
					end else begin
						chan_r <= chan_r + 1'b1;
					end
				end
				ST_START: begin
					if (tick && phase_r == 2'h1) begin
						sda_drv_r <= 1'b1;
						bit_r <= '0;
						shift_r <= (chan_r == 3'(`ASB_SINGLE_CH)) ? {single_cfg.dev, rd_phase_r}
							: {chan_cfg[chan_r[1:0]].dev, rd_phase_r};
						state_r <= ST_ADDR;
					end
				end
				ST_ADDR, ST_WBYTE: begin
					if (tick && phase_r == 2'h3) begin
						scl_drv_r <= 1'b1;
						sda_drv_r <= ~shift_r[7];
					end else if (tick && phase_r == 2'h1) begin
						scl_drv_r <= 1'b0;
						if (shift_r[7] && !sda_now) begin
							arb_r <= 1'b1;
							state_r <= ST_IDLE;
						end else if (bit_r == `ASB_BIT_LAST) begin
							state_r <= (state_r == ST_ADDR) ? ST_AACK : ST_WACK;
						end else begin
							shift_r <= {shift_r[6:0], 1'b0};
							bit_r <= bit_r + 1'b1;
						end
					end
				end
				ST_AACK, ST_WACK: begin
					if (tick && phase_r == 2'h3) begin
						scl_drv_r <= 1'b1;
						sda_drv_r <= 1'b0;
					end else if (tick && phase_r == 2'h1) begin
						scl_drv_r <= 1'b0;
						bit_r <= '0;
						if (sda_now) begin
							nack_r <= 1'b1;
							state_r <= ST_STOP;
						end else if (state_r == ST_AACK && rd_phase_r) begin
							state_r <= ST_RBYTE;
						end else if (state_r == ST_AACK) begin
							shift_r <= (chan_r == 3'(`ASB_SINGLE_CH)) ? single_cfg.reg_addr
								: chan_cfg[chan_r[1:0]].reg_addr;
							state_r <= ST_WBYTE;
						end else if (chan_r == 3'(`ASB_SINGLE_CH) && !single_cfg.rd && !rd_phase_r) begin
							shift_r <= single_cfg.wdata;
							rd_phase_r <= 1'b1;
							state_r <= ST_WBYTE;
						end else if (chan_r == 3'(`ASB_SINGLE_CH) && !single_cfg.rd) begin
							single_ev_r <= 1'b1;
							state_r <= ST_STOP;
						end else begin
							rd_phase_r <= 1'b1;
							state_r <= ST_RSTART;
						end
					end
				end
				ST_RSTART: begin
					if (tick && phase_r == 2'h3) begin
						scl_drv_r <= 1'b1;
						sda_drv_r <= 1'b0;
					end else if (tick && phase_r == 2'h1) begin
						scl_drv_r <= 1'b0;
						state_r <= ST_START;
					end
				end
				ST_RBYTE: begin
					if (tick && phase_r == 2'h3) begin
						scl_drv_r <= 1'b1;
						sda_drv_r <= 1'b0;
					end else if (tick && phase_r == 2'h1) begin
						scl_drv_r <= 1'b0;
						shift_r <= {shift_r[6:0], sda_now};
						if (bit_r == `ASB_BIT_LAST)
							state_r <= ST_RACK;
						else
							bit_r <= bit_r + 1'b1;
					end
				end
				ST_RACK: begin
					if (tick && phase_r == 2'h3) begin
						scl_drv_r <= 1'b1;
						sda_drv_r <= (left_r != `ASB_BYTE_CNT_W'(1));
					end else if (tick && phase_r == 2'h1 && (push_ready || !push)) begin
						scl_drv_r <= 1'b0;
						bit_r <= '0;
						if (chan_r == 3'(`ASB_SINGLE_CH))
							single_ev_r <= 1'b1;
						else if (slot_r != `ASB_BYTE_CNT_W'(`ASB_MAX_BURST_BYTES - 1))
							slot_r <= slot_r + 1'b1;
						left_r <= left_r - 1'b1;
						state_r <= (left_r == `ASB_BYTE_CNT_W'(1)) ? ST_STOP : ST_RBYTE;
					end
				end
				ST_STOP: begin
					if (tick && phase_r == 2'h3) begin
						sda_drv_r <= 1'b1;
						scl_drv_r <= 1'b1;
					end else if (tick && phase_r == 2'h0) begin
						scl_drv_r <= 1'b0;
					end else if (tick && phase_r == 2'h1) begin
						sda_drv_r <= 1'b0;
						chan_r <= chan_r + 1'b1;
						state_r <= ST_NEXT;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ==============================================================
	// Result storage
	// ==============================================================
	assign push = state_r == ST_RACK && tick && phase_r == 2'h1 && chan_r != 3'(`ASB_SINGLE_CH)
		&& chan_cfg[chan_r[1:0]].to_fifo;

	always_ff @(posedge clk) begin
		if (rst) begin
			sensor_data  <= '{default: 8'h00};
			single_rdata <= 8'h00;
		end else if (state_r == ST_RACK && tick && phase_r == 2'h1 && (push_ready || !push)) begin
			if (chan_r == 3'(`ASB_SINGLE_CH))
				single_rdata <= shift_r;
			else
				sensor_data[slot_r] <= shift_r;
		end
	end

	asb_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (shift_r),
		.in_valid  (push),
		.in_ready  (push_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.count     (fifo_count)
	);

	// ==============================================================
	// Pin drive
	// ==============================================================
	assign events      = '{nack: nack_r, lost_arb: arb_r, data_ready: any_data_r, single_done: single_ev_r};
	assign busy        = (state_r != ST_IDLE);

	// Open-drain pins only ever pull low; bypass mirrors lows across
	always_comb begin
		sensor_bus_clock_pin_out = 1'b0;
		sensor_bus_data_pin_out  = 1'b0;
		host_scl_out             = 1'b0;
		host_sda_out             = 1'b0;
		if (bypass_on) begin
			sensor_bus_clock_pin_oe = !host_scl_sync_r[1] && (scl_back_r == 3'h0);
			sensor_bus_data_pin_oe  = !host_sda_sync_r[1] && (sda_back_r == 3'h0);
			host_scl_oe             = !aux_scl_sync_r[1] && (scl_fwd_r == 3'h0);
			host_sda_oe             = !aux_sda_sync_r[1] && (sda_fwd_r == 3'h0);
		end else begin
			sensor_bus_clock_pin_oe = scl_drv_r;
			sensor_bus_data_pin_oe  = sda_drv_r;
			host_scl_oe             = 1'b0;
			host_sda_oe             = 1'b0;
		end
	end
endmodule // asb_master

// ### verif/asb_master_props.sv
// Checker for the auxiliary sensor bus master
`timescale 1ns/10ps
module asb_master_props
	import asb_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic                       clk,
	input wire logic                       rst,
	input wire logic                       bypass_en,
	input wire logic                       spi_mode,
	input wire logic                       busy,
	input wire asb_event_s                 events,
	input wire logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_count,
	input wire logic                       fifo_valid,
	input wire logic                       host_scl_in,
	input wire logic                       host_sda_in,
	input wire logic                       host_sda_oe,
	input wire logic                       host_scl_oe,
	input wire logic                       sensor_bus_clock_pin_oe,
	input wire logic                       sensor_bus_data_pin_oe
);
	// ==========
	// Bypass settle counter
	logic [11:0] bp_cnt_r;
	always_ff @(posedge clk) begin
		if (rst || !bypass_en || spi_mode)
			bp_cnt_r <= 12'h000;
		else if (bp_cnt_r != 12'hfff)
			bp_cnt_r <= bp_cnt_r + 12'h001;
	end
	default clocking dcb @(posedge clk); endclocking
	default disable iff (rst);
	sequence host_idle_s;
		(bp_cnt_r == 12'hfff && host_scl_in && host_sda_in) [*4];
	endsequence
	sequence host_low_s;
		(bp_cnt_r == 12'hfff && !host_sda_in) [*4];
	endsequence
	// ==========
	// Properties
	chk_reset_quiet: assert property ($past(rst) |-> !sensor_bus_clock_pin_oe && !sensor_bus_data_pin_oe
		&& events == '0 && fifo_count == '0) else $error("outputs active after reset");
	chk_bypass_idle: assert property (host_idle_s |-> !sensor_bus_clock_pin_oe && !sensor_bus_data_pin_oe)
		else $error("sensor pins driven in idle bypass");
	chk_bypass_mirror: assert property (host_low_s |-> sensor_bus_data_pin_oe)
		else $error("host low not passed to sensor data pin");
	chk_spi_no_host: assert property (spi_mode |-> !host_sda_oe && !host_scl_oe)
		else $error("host pins driven in spi mode");
	chk_master_idle: assert property (!bypass_en && !busy && $past(!busy) |-> !sensor_bus_clock_pin_oe
		&& !sensor_bus_data_pin_oe) else $error("sensor pins driven while idle");
	chk_ready_pulse: assert property (events.data_ready |=> !events.data_ready)
		else $error("data ready longer than one cycle");
	chk_ready_idle: assert property (events.data_ready |-> ##[0:4] !busy)
		else $error("busy after data ready");
	chk_nack_pulse: assert property (events.nack |=> !events.nack)
		else $error("nack event longer than one cycle");
	chk_fifo_step: assert property (fifo_count <= $past(fifo_count) + 1 && fifo_count + 1 >= $past(fifo_count))
		else $error("fifo count jumped");
	chk_fifo_valid: assert property ((fifo_count == '0) == !fifo_valid && fifo_count <= FIFO_DEPTH)
		else $error("fifo valid disagrees with count");
	chk_start_frame: assert property (!bypass_en && $rose(busy) |-> ##[1:600]
		(($rose(sensor_bus_data_pin_oe) && !sensor_bus_clock_pin_oe) || !busy)) else $error("no start condition");
endmodule // asb_master_props
bind asb_master asb_master_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.clk, .rst, .bypass_en, .spi_mode,
	.busy, .events, .fifo_count, .fifo_valid, .host_scl_in, .host_sda_in, .host_sda_oe, .host_scl_oe,
	.sensor_bus_clock_pin_oe, .sensor_bus_data_pin_oe);

// ### verif/asb_sensor_model.sv
// Behavioural sensor on the auxiliary two-wire bus
`timescale 1ns/10ps
module asb_sensor_model #(
	parameter logic [6:0] ADDR = 7'h0c
) (
	input  wire logic  scl,
	input  wire logic  sda,
	input  wire logic  nack_all,
	output logic       sda_oe,
	output logic [7:0] last_wr
);
	logic [7:0] sh;
	logic [7:0] ptr;
	logic       tx;
	logic       hit;
	int         bitc;
	int         nbyte;
	initial begin
		sda_oe = 1'b0;
		last_wr = 8'h00;
		ptr = 8'h00;
		tx = 1'b0;
		hit = 1'b0;
		bitc = 0;
		nbyte = 0;
	end
	always @(negedge sda) if (scl) begin
		bitc = 0;
		nbyte = 0;
		tx = 1'b0;
		sda_oe = 1'b0;
	end
	always @(posedge sda) if (scl) begin
		tx = 1'b0;
		hit = 1'b0;
		sda_oe = 1'b0;
	end
	always @(posedge scl) begin
		if (bitc < 8 && !tx) sh = {sh[6:0], sda};
		if (bitc == 8 && tx && sda) tx = 1'b0;
		bitc = bitc + 1;
	end
	always @(negedge scl) begin
		if (bitc == 8 && tx) sda_oe = 1'b0;
		else if (bitc == 8) begin
			if (nbyte == 0) hit = (sh[7:1] == ADDR);
			if (nbyte == 0) tx = hit & sh[0];
			else if (hit && nbyte == 1) ptr = sh;
			else if (hit) last_wr = sh;
			nbyte = nbyte + 1;
			sda_oe = hit && !nack_all;
		end else if (bitc == 9) begin
			bitc = 0;
			sda_oe = 1'b0;
			if (tx) sh = ptr;
			if (tx) ptr = ptr + 8'h01;
			if (tx) sda_oe = !sh[7];
		end else if (tx && bitc > 0) sda_oe = !sh[7-bitc];
	end
endmodule // asb_sensor_model

// ### verif/asb_master_tb.sv
// Testbench for the auxiliary sensor bus master
`timescale 1ns/10ps
module asb_master_tb
	import asb_pkg::*;
;
	logic            clk, link_clk, rst, master_en, bypass_en, spi_mode, start_cycle, fifo_ready;
	logic            nack_all, h_scl, h_sda, busy, fifo_valid, scl_w, sda_w, m_oe;
	logic            host_scl_in, host_sda_in, host_sda_out, host_sda_oe, host_scl_out, host_scl_oe;
	logic            clk_out, clk_oe, dat_out, dat_oe;
	asb_chan_cfg_s   chan_cfg [4];
	asb_single_cfg_s single_cfg;
	asb_event_s      events;
	logic [7:0]      single_rdata, fifo_data, last_wr;
	logic [7:0]      sensor_data [24];
	logic [5:0]      fifo_count;
	int              n_fail, checks, n_rdy, n_nack;
	assign scl_w = !clk_oe;
	assign sda_w = !(dat_oe | m_oe);
	assign host_scl_in = !(h_scl | host_scl_oe);
	assign host_sda_in = !(h_sda | host_sda_oe);
	asb_master #(.FIFO_DEPTH(32), .HALF_CYC(4)) u_dut (.clk, .rst, .link_clk, .master_en, .bypass_en,
		.spi_mode, .start_cycle, .chan_cfg, .single_cfg, .single_rdata, .sensor_data, .events, .busy,
		.fifo_data, .fifo_valid, .fifo_ready, .fifo_count, .host_scl_in, .host_sda_in, .host_sda_out,
		.host_sda_oe, .host_scl_out, .host_scl_oe, .sensor_bus_clock_pin_in(scl_w),
		.sensor_bus_clock_pin_out(clk_out), .sensor_bus_clock_pin_oe(clk_oe),
		.sensor_bus_data_pin_in(sda_w), .sensor_bus_data_pin_out(dat_out), .sensor_bus_data_pin_oe(dat_oe));
	asb_sensor_model u_sensor (.scl(scl_w), .sda(sda_w), .nack_all, .sda_oe(m_oe), .last_wr);
	// ==========
	// Clocks and event monitor
	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #6 link_clk = !link_clk;
	end
	always @(negedge clk) begin
		if (events.data_ready === 1'b1) n_rdy++;
		if (events.nack === 1'b1) n_nack++;
	end
	// ==========
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic sweep(input logic [3:0] fifo_sel, input int exp_rdy);
		int k0;
		k0 = n_rdy;
		for (int k = 0; k < 4; k++) chan_cfg[k] = '{1'b1, 1'b1, 7'h0c, 8'((k + 1) * 16), 5'h06, fifo_sel[k]};
		@(negedge link_clk) start_cycle = 1'b1;
		@(negedge link_clk) start_cycle = 1'b0;
		for (int t = 0; t < 20 && !busy; t++) tick(1);
		for (int t = 0; t < 30000 && busy; t++) tick(1);
		tick(2);
		chk(n_rdy, k0 + exp_rdy);
	endtask
	// ==========
	// Scenarios
	task automatic t_burst();
		single_cfg = '{1'b1, 1'b0, 7'h0c, 8'h30, 8'h5a};
		sweep(4'h5, 1);
		for (int i = 0; i < 24; i++) chk(sensor_data[i], ((i / 6) + 1) * 16 + (i % 6));
		chk(fifo_count, 12);
		chk(last_wr, 8'h5a);
	endtask
	task automatic t_fifo();
		single_cfg = '{1'b1, 1'b1, 7'h0c, 8'h40, 8'h00};
		sweep(4'h7, 1);
		chk(fifo_count, 30);
		chk(single_rdata, 8'h40);
		for (int i = 0; i < 30; i++) begin
			if (i < 12) chk(fifo_data, (i < 6) ? 8'h10 + i : 8'h2a + i);
			fifo_ready = 1'b1;
			tick(1);
			fifo_ready = 1'b0;
			tick(1);
			chk(fifo_count, 29 - i);
		end
		chk(fifo_valid, 1'b0);
	endtask
	task automatic t_nack();
		nack_all = 1'b1;
		single_cfg.en = 1'b0;
		sweep(4'h0, 0);
		chk(n_nack != 0, 1'b1);
		nack_all = 1'b0;
	endtask
	task automatic t_bypass();
		bypass_en = 1'b1;
		tick(4200);
		@(negedge link_clk) start_cycle = 1'b1;
		@(negedge link_clk) start_cycle = 1'b0;
		tick(50);
		chk(busy, 1'b0);
		h_sda = 1'b1;
		tick(8);
		chk(dat_oe, 1'b1);
		h_sda = 1'b0;
		tick(8);
		chk(dat_oe, 1'b0);
		chk(sensor_data[0], 8'h10);
	endtask
	task automatic t_spi();
		spi_mode = 1'b1;
		tick(10);
		h_sda = 1'b1;
		tick(8);
		chk(dat_oe, 1'b0);
		chk(host_sda_oe, 1'b0);
		h_sda = 1'b0;
		spi_mode = 1'b0;
		bypass_en = 1'b0;
		tick(20);
	endtask
	// ==========
	// Main sequence and watchdog
	initial begin
		{n_fail, checks, n_rdy, n_nack} = '0;
		{rst, master_en} = 2'h3;
		{bypass_en, spi_mode, start_cycle, fifo_ready, nack_all, h_scl, h_sda} = '0;
		single_cfg = '0;
		for (int k = 0; k < 4; k++) chan_cfg[k] = '0;
		tick(12);
		rst = 1'b0;
		tick(4);
		chk({dat_oe, clk_oe, host_sda_oe, fifo_count}, 0);
		chk(sensor_data[23], 8'h00);
		t_burst();
		t_fifo();
		t_nack();
		t_bypass();
		t_spi();
		give_verdict();
	end
	initial begin
		#900us;
		n_fail++;
		give_verdict();
	end
endmodule // asb_master_tb
